// ===== hdl/epi_host.sv
`timescale 1ns/1ps
module epi_host
  import epi_pkg::*;
#(
  parameter int IDLE_WIN_CYCLES = IDLE_WIN_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic ctrl_busy,
  output logic prog_timeout,
  input wire logic protect_req,
  output logic protect_active,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic program_protect_n,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [DATA_W-1:0] mem_data_in,
  input wire logic mem_rdy_busy_n
);

  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_LOAD = 7'b000_0010,
    S_GAP = 7'b000_0100,
    S_READ = 7'b000_1000,
    S_IDLE_WIN = 7'b001_0000,
    S_PROG = 7'b010_0000,
    S_SETTLE = 7'b100_0000
  } epi_hst_t;

  typedef struct packed {
    epi_hst_t st;
    logic [CNT_W-1:0] cnt;
    epi_op_t op;
    logic [2:0] step;
    logic [ADDR_W-1:0] uaddr;
    logic [DATA_W-1:0] udata;
    logic start;
    logic wr;
    logic [ADDR_W-1:0] caddr;
    logic [DATA_W-1:0] cdata;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic protect_n;
    logic timeout;
  } epi_host_state_t;

  epi_host_state_t r;
  epi_host_state_t next_r;
  epi_cyc_if cyc();

  logic seq_done;
  logic idle_take;
  logic page_fit;
  logic page_take;
  epi_load_t first_load;
  epi_load_t step_load;

  assign seq_done = r.step >= epi_seq_len(r.op);
  // Commands wait while the device is held protected; it would ignore them anyway.
  assign idle_take = (r.st == S_IDLE) && (protect_req == ~r.protect_n) && r.protect_n;
  // An unlock page stores nothing, so a write after it must open a page of its own.
  assign page_fit = seq_done && (r.op != OP_UNLOCK) && (epi_op_t'(cmd_op) == OP_WRITE)
                    && epi_same_page(cmd_addr, r.uaddr);
  assign page_take = (r.st == S_GAP) && page_fit
                     && (r.cnt >= CNT_W'(LOAD_MIN_CYC))
                     && (r.cnt < CNT_W'(LOAD_CLOSE_CYC));
  assign cmd_ready = idle_take || page_take;
  assign first_load = epi_seq_word(epi_op_t'(cmd_op), 3'h0, cmd_addr, cmd_wdata);
  assign step_load = epi_seq_word(r.op, r.step, r.uaddr, r.udata);

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.cnt = r.cnt + 1'b1;
    case (r.st)
      S_IDLE: begin
        next_r.cnt = '0;
        if (protect_req == r.protect_n) begin
          next_r.protect_n = ~protect_req;
          next_r.st = S_SETTLE;
        end else if (cmd_valid && idle_take) begin
          next_r.op = epi_op_t'(cmd_op);
          next_r.uaddr = cmd_addr;
          next_r.udata = cmd_wdata;
          next_r.step = 3'h0;
          next_r.start = 1'b1;
          next_r.caddr = first_load.addr;
          next_r.cdata = first_load.data;
          next_r.wr = epi_op_t'(cmd_op) != OP_READ;
          next_r.st = (epi_op_t'(cmd_op) == OP_READ) ? S_READ : S_LOAD;
        end
      end
      S_READ: begin
        if (cyc.done) begin
          next_r.rsp_valid = 1'b1;
          next_r.rdata = cyc.rdata;
          next_r.st = S_IDLE;
        end
      end
      S_LOAD: begin
        next_r.cnt = '0;
        if (cyc.done) begin
          next_r.step = r.step + 3'h1;
          next_r.st = S_GAP;
        end
      end
      S_GAP: begin
        if (!seq_done) begin
          if (r.cnt >= CNT_W'(LOAD_MIN_CYC)) begin
            // Command bytes and the data byte form one page load, so spacing applies.
            next_r.start = 1'b1;
            next_r.caddr = step_load.addr;
            next_r.cdata = step_load.data;
            next_r.st = S_LOAD;
          end
        end else if (cmd_valid && page_take) begin
          next_r.op = OP_WRITE;
          next_r.uaddr = cmd_addr;
          next_r.udata = cmd_wdata;
          next_r.step = 3'h0;
          next_r.start = 1'b1;
          next_r.caddr = cmd_addr;
          next_r.cdata = cmd_wdata;
          next_r.st = S_LOAD;
        end else if ((cmd_valid && !page_fit) || r.cnt >= CNT_W'(LOAD_CLOSE_CYC)) begin
          // A fitting write that comes too early waits for the gap instead of closing.
          next_r.st = S_IDLE_WIN;
        end
      end
      S_IDLE_WIN: begin
        // The count carries on from the last load, so the window is measured from it.
        if (r.cnt >= CNT_W'(IDLE_WIN_CYCLES)) begin
          next_r.cnt = '0;
          next_r.st = S_PROG;
        end
      end
      S_PROG: begin
        // Nothing is issued here: writes would be ignored until the cycle ends.
        if (mem_rdy_busy_n) begin
          next_r.st = S_IDLE;
        end else if (r.cnt >= CNT_W'(PROG_CYCLES)) begin
          next_r.timeout = 1'b1;
          next_r.st = S_IDLE;
        end
      end
      S_SETTLE: begin
        if (r.cnt >= CNT_W'(SETTLE_CYCLES)) begin
          next_r.st = S_IDLE;
        end
      end
      default: begin
        next_r.st = S_IDLE;
      end
    endcase
    if (r.st == S_IDLE && cmd_valid && idle_take) begin
      next_r.timeout = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{st: S_IDLE, cnt: '0, op: OP_READ, step: 3'h0, uaddr: '0, udata: '0,
             start: 1'b0, wr: 1'b0, caddr: '0, cdata: '0, rsp_valid: 1'b0,
             rdata: '0, protect_n: 1'b0, timeout: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign cyc.start = r.start;
  assign cyc.wr = r.wr;
  assign cyc.addr = r.caddr;
  assign cyc.wdata = r.cdata;

  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rdata;
  assign ctrl_busy = r.st != S_IDLE;
  assign prog_timeout = r.timeout;
  assign protect_active = ~r.protect_n;
  assign program_protect_n = r.protect_n;

  epi_pin_cycle u_cycle (
    .clk(clk),
    .nrst(nrst),
    .cyc(cyc.slave),
    .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n),
    .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe),
    .mem_data_in(mem_data_in)
  );

endmodule

// ===== common/epi_pkg.sv
// Operation
// - Read is chip select low, gate low, strobe high, protect high.
// - Write is chip select low, gate high, strobe low, protect high.
// - Host starts each page byte load 0.55 to 30 us after the previous.
// - Host waits at least 100 us around protect input transitions; the host waits only after a transition, in S_SETTLE.
// - Host presents address bits 14 and 15 in their defined order.
// - Lock is AA, 55, A0 command writes followed by one data write.
// - Unlock is six command writes AA, 55, 80, AA, 55, 20; nothing stored.
// - Host keeps address bits 7 to 16 fixed within one page load; lock and unlock key loads go to 5555 and AAAA instead.
package epi_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int PAGE_LSB = 7;
  localparam int CLK_PERIOD_NS = 20;

  function automatic int epi_ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WP_NS = 250;
  localparam int WP_CYC = epi_ceil_cyc(WP_NS);
  localparam int DH_NS = 10;
  localparam int DH_CYC = epi_ceil_cyc(DH_NS);
  localparam int ACC_NS = 150;
  localparam int ACC_CYC = epi_ceil_cyc(ACC_NS) + 1;
  localparam int DF_NS = 50;
  localparam int DF_CYC = epi_ceil_cyc(DF_NS);
  localparam int CYC_CNT_W = 4;

  localparam int LOAD_MIN_NS = 550;
  localparam int LOAD_MIN_CYC = epi_ceil_cyc(LOAD_MIN_NS);
  localparam int LOAD_MAX_NS = 30000;
  localparam int LOAD_MAX_CYC = LOAD_MAX_NS / CLK_PERIOD_NS;
  // The gap count starts after the strobe and hold, so the close point is pulled in.
  localparam int LOAD_CLOSE_CYC = LOAD_MAX_CYC - WP_CYC - DH_CYC - 1;
  localparam int IDLE_WIN_US = 100;
  localparam int IDLE_WIN_CYC = IDLE_WIN_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_MS = 10;
  localparam int PROG_CYC = PROG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  localparam logic [ADDR_W-1:0] SDP_ADDR_A = 17'h0_5555;
  localparam logic [ADDR_W-1:0] SDP_ADDR_B = 17'h0_AAAA;
  localparam logic [7:0] SDP_KEY_1 = 8'hAA;
  localparam logic [7:0] SDP_KEY_2 = 8'h55;
  localparam logic [7:0] SDP_LOCK_KEY = 8'hA0;
  localparam logic [7:0] SDP_UNLOCK_KEY_1 = 8'h80;
  localparam logic [7:0] SDP_UNLOCK_KEY_2 = 8'h20;
  localparam logic [2:0] LEN_WRITE = 3'h1;
  localparam logic [2:0] LEN_LOCK = 3'h4;
  localparam logic [2:0] LEN_UNLOCK = 3'h6;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOCK_WRITE = 2'h2,
    OP_UNLOCK = 2'h3
  } epi_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } epi_load_t;

  function automatic logic [2:0] epi_seq_len(input epi_op_t op);
    case (op)
      OP_LOCK_WRITE: return LEN_LOCK;
      OP_UNLOCK: return LEN_UNLOCK;
      default: return LEN_WRITE;
    endcase
  endfunction

  function automatic logic epi_same_page(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:PAGE_LSB] == b[ADDR_W-1:PAGE_LSB];
  endfunction

  // Command bytes go to every byte lane so each of the four dies sees the key.
  function automatic epi_load_t epi_seq_word(input epi_op_t op, input logic [2:0] step,
                                             input logic [ADDR_W-1:0] a,
                                             input logic [DATA_W-1:0] d);
    epi_load_t w;
    w.addr = a;
    w.data = d;
    // The lock sequence carries its user word as the fourth load, not as a key.
    if (op == OP_UNLOCK || (op == OP_LOCK_WRITE && step < 3'h3)) begin
      case (step)
        3'h0, 3'h3: begin
          w.addr = SDP_ADDR_A;
          w.data = {4{SDP_KEY_1}};
        end
        3'h1, 3'h4: begin
          w.addr = SDP_ADDR_B;
          w.data = {4{SDP_KEY_2}};
        end
        3'h2: begin
          w.addr = SDP_ADDR_A;
          w.data = (op == OP_UNLOCK) ? {4{SDP_UNLOCK_KEY_1}} : {4{SDP_LOCK_KEY}};
        end
        3'h5: begin
          w.addr = SDP_ADDR_A;
          w.data = {4{SDP_UNLOCK_KEY_2}};
        end
        default: begin
          w.addr = a;
          w.data = d;
        end
      endcase
    end
    return w;
  endfunction

endpackage

// ===== common/epi_cyc_if.sv
`timescale 1ns/1ps
interface epi_cyc_if;
  import epi_pkg::*;
  logic start;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master(output start, output wr, output addr, output wdata,
                 input done, input rdata);
  modport slave(input start, input wr, input addr, input wdata,
                output done, output rdata);
endinterface

// ===== hdl/epi_pin_cycle.sv
`timescale 1ns/1ps
module epi_pin_cycle
  import epi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  epi_cyc_if.slave cyc,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [DATA_W-1:0] mem_data_in
);

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_STROBE = 4'b0010,
    C_HOLD = 4'b0100,
    C_RECOV = 4'b1000
  } epi_cst_t;

  typedef struct packed {
    epi_cst_t st;
    logic [CYC_CNT_W-1:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic done;
    logic [DATA_W-1:0] rdata;
  } epi_cyc_state_t;

  epi_cyc_state_t r;
  epi_cyc_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.cnt = r.cnt + 1'b1;
    case (r.st)
      C_IDLE: begin
        next_r.cnt = '0;
        if (cyc.start) begin
          next_r.st = C_STROBE;
          next_r.wr = cyc.wr;
          next_r.addr = cyc.addr;
          next_r.dout = cyc.wdata;
          next_r.ce_n = 1'b0;
          next_r.doe = cyc.wr;
          next_r.we_n = ~cyc.wr;
          next_r.oe_n = cyc.wr;
        end
      end
      C_STROBE: begin
        if (r.wr && r.cnt == CYC_CNT_W'(WP_CYC - 1)) begin
          // Data is taken on this rising edge, so it stays driven through the hold.
          next_r.we_n = 1'b1;
          next_r.cnt = '0;
          next_r.st = C_HOLD;
        end else if (!r.wr && r.cnt == CYC_CNT_W'(ACC_CYC - 1)) begin
          next_r.rdata = mem_data_in;
          next_r.oe_n = 1'b1;
          next_r.ce_n = 1'b1;
          next_r.cnt = '0;
          next_r.st = C_RECOV;
        end
      end
      C_HOLD: begin
        if (r.cnt == CYC_CNT_W'(DH_CYC - 1)) begin
          next_r.doe = 1'b0;
          next_r.ce_n = 1'b1;
          next_r.cnt = '0;
          next_r.st = C_RECOV;
        end
      end
      C_RECOV: begin
        // The device may still drive the data bus briefly after the gate rises.
        if (r.cnt == CYC_CNT_W'(DF_CYC - 1)) begin
          next_r.done = 1'b1;
          next_r.st = C_IDLE;
        end
      end
      default: begin
        next_r.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{st: C_IDLE, cnt: '0, wr: 1'b0, addr: '0, dout: '0, doe: 1'b0,
             ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, done: 1'b0, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  assign cyc.done = r.done;
  assign cyc.rdata = r.rdata;
  assign mem_addr = r.addr;
  assign mem_ce_n = r.ce_n;
  assign mem_oe_n = r.oe_n;
  assign mem_we_n = r.we_n;
  assign mem_data_out = r.dout;
  assign mem_data_oe = r.doe;

endmodule

// ===== tb/epi_host_asserts.sv
`timescale 1ns/1ps
module epi_host_asserts
  import epi_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic rsp_valid,
  input wire logic protect_active,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic program_protect_n,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe
);
  logic [4:0] we_low;
  logic [10:0] gap;
  logic [15:0] prot_age;
  logic prot_last;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Counters saturate so that a long idle stretch never wraps into a false short gap.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_low <= '0;
      gap <= '1;
      prot_age <= '0;
      prot_last <= 1'b0;
    end else begin
      we_low <= mem_we_n ? '0 : ((we_low == 5'h1f) ? we_low : we_low + 5'h1);
      gap <= $fell(mem_we_n) ? '0 : ((gap == 11'h7ff) ? gap : gap + 11'h1);
      prot_age <= (program_protect_n != prot_last) ? '0 :
                  ((prot_age == 16'hffff) ? prot_age : prot_age + 16'h1);
      prot_last <= program_protect_n;
    end
  end
  read_strobes_a: assert property (
    !mem_ce_n && !mem_oe_n |-> mem_we_n && program_protect_n && !mem_data_oe)
    else $error("Read cycle overlaps a write or protect.");
  write_strobes_a: assert property (
    !mem_we_n |-> !mem_ce_n && mem_oe_n && program_protect_n && mem_data_oe)
    else $error("Write strobe without select, gate high or data drive.");
  strobe_width_a: assert property ($rose(mem_we_n) |-> we_low >= WP_CYC)
    else $error("Write strobe too short.");
  write_stable_a: assert property (
    !mem_we_n && !$past(mem_we_n) |-> $stable(mem_addr) && $stable(mem_data_out))
    else $error("Address or data moved under the write strobe.");
  load_gap_a: assert property ($fell(mem_we_n) |-> gap >= LOAD_MIN_CYC - 1)
    else $error("Byte loads closer than the minimum interval.");
  protect_settle_a: assert property (!mem_ce_n |-> prot_age >= SETTLE_CYCLES)
    else $error("Access too soon after a protect change.");
  protect_mirror_a: assert property (
    !program_protect_n |-> mem_ce_n && mem_we_n && !mem_data_oe)
    else $error("Device accessed while the protect pin is low.");
  protect_refuse_a: assert property (protect_active |-> !cmd_ready)
    else $error("Command accepted while protected.");
  read_answer_a: assert property (
    cmd_valid && cmd_ready && cmd_op == 2'h0 |-> ##15 rsp_valid)
    else $error("Read answer not at the expected cycle.");
  bus_turn_a: assert property (mem_data_oe |-> mem_oe_n)
    else $error("Host drives data while the output gate is low.");
  cover property (cmd_valid && cmd_ready && cmd_op == 2'h2);
  cover property (cmd_valid && cmd_ready && cmd_op == 2'h3);
  cover property ($fell(mem_we_n) && gap < 11'h064);
  cover property ($rose(protect_active));
endmodule

bind epi_host epi_host_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_epi_host_asserts (.*);

// ===== tb/epi_eeprom_model.sv
`timescale 1ns/1ps
module epi_eeprom_model
  import epi_pkg::*;
#(
  parameter int BL_CYC = 45,
  parameter int WC_CYC = 100
) (
  input wire logic clk,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic program_protect_n,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [DATA_W-1:0] mem_data_in,
  output logic mem_rdy_busy_n
);
  logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]];
  epi_load_t page_q[$];
  logic [ADDR_W-1:0] lat_addr = '0;
  logic [DATA_W-1:0] last_data = '0;
  logic [DATA_W-1:0] bus_last = '0;
  logic locked = 1'b0;
  logic loading = 1'b0;
  logic prog = 1'b0;
  int idle = 0;
  int left = 0;
  wire rd_en = !mem_ce_n && !mem_oe_n && mem_we_n && program_protect_n;

  function automatic logic key(input int i, input logic [ADDR_W-1:0] a, input logic [7:0] b);
    return i < page_q.size() && page_q[i].addr == a && page_q[i].data[7:0] == b;
  endfunction

  // Address latches on the falling strobe, data on the rising one.
  // Chip select falls in the same step as the strobe, so only the rise checks it.
  always @(negedge mem_we_n) begin
    if (mem_oe_n && program_protect_n)
      lat_addr = mem_addr;
  end
  always @(posedge mem_we_n) begin
    if (!mem_ce_n && mem_oe_n && program_protect_n && !prog) begin
      last_data = mem_data_oe ? mem_data_out : ~last_data;
      page_q.push_back('{lat_addr, last_data});
      loading = 1'b1;
    end
  end
  always @(posedge clk) begin
    if (rd_en)
      bus_last <= mem_data_in;
    if (!program_protect_n) begin
      page_q.delete();
      loading = 1'b0;
      prog = 1'b0;
    end else if (loading && idle >= BL_CYC) begin
      if (key(0, SDP_ADDR_A, 8'hAA) && key(1, SDP_ADDR_B, 8'h55) && key(2, SDP_ADDR_A, 8'h80)
          && key(3, SDP_ADDR_A, 8'hAA) && key(4, SDP_ADDR_B, 8'h55)
          && key(5, SDP_ADDR_A, 8'h20)) begin
        locked = 1'b0;
      end else if (key(0, SDP_ADDR_A, 8'hAA) && key(1, SDP_ADDR_B, 8'h55)
                   && key(2, SDP_ADDR_A, 8'hA0) && page_q.size() > 3) begin
        locked = 1'b1;
        for (int i = 3; i < page_q.size(); i++)
          mem[page_q[i].addr] = page_q[i].data;
      end else if (!locked) begin
        foreach (page_q[i])
          mem[page_q[i].addr] = page_q[i].data;
      end
      page_q.delete();
      loading = 1'b0;
      prog = 1'b1;
      left = WC_CYC;
    end else if (prog) begin
      left--;
      prog = left > 0;
    end
    // Busy moves just after the edge so that the host never races it.
    mem_rdy_busy_n <= !(loading || prog);
    idle = mem_we_n ? idle + 1 : 0;
  end
  // A released bus shows the inverse of its last value rather than holding it.
  always @* begin
    if (rd_en && prog)
      mem_data_in = ~last_data;
    else if (rd_en)
      mem_data_in = mem.exists(mem_addr) ? mem[mem_addr] : '1;
    else
      mem_data_in = ~bus_last;
  end
endmodule

// ===== tb/epi_host_tb.sv
`timescale 1ns/1ps
module epi_host_tb;
  import epi_pkg::*;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic protect_req = 1'b0;
  logic cmd_ready, rsp_valid, ctrl_busy, prog_timeout, protect_active;
  logic mem_ce_n, mem_oe_n, mem_we_n, program_protect_n, mem_data_oe, mem_rdy_busy_n;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] rsp_rdata, mem_data_out, mem_data_in;
  int mismatches = 0;
  int checks = 0;

  always #10 clk = ~clk;

  epi_host #(.IDLE_WIN_CYCLES(50), .PROG_CYCLES(200), .SETTLE_CYCLES(SETTLE)) i_epi_host (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .ctrl_busy(ctrl_busy), .prog_timeout(prog_timeout), .protect_req(protect_req),
    .protect_active(protect_active), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .program_protect_n(program_protect_n),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
    .mem_rdy_busy_n(mem_rdy_busy_n));
  epi_eeprom_model #(.BL_CYC(45), .WC_CYC(100)) i_epi_eeprom_model (
    .clk(clk), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .program_protect_n(program_protect_n), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in), .mem_rdy_busy_n(mem_rdy_busy_n));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Holds the command until the edge that takes it; a command that is never taken counts.
  task automatic issue(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n < 4000}, 32'h1);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    issue(2'h0, a, '0);
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(rsp_rdata, exp);
  endtask

  task automatic t_settle;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n >= SETTLE && n < 100}, 32'h1);
    check({31'h0, ctrl_busy}, 32'h0);
    check({31'h0, program_protect_n}, 32'h1);
  endtask

  task automatic t_write_read;
    issue(2'h1, 17'h0_0100, 32'h1234_5678);
    @(negedge clk);
    check({31'h0, ctrl_busy}, 32'h1);
    rd(17'h0_0100, 32'h1234_5678);
    check({31'h0, prog_timeout}, 32'h0);
  endtask

  task automatic t_page;
    logic [ADDR_W-1:0] pa [3] = '{17'h0_0200, 17'h0_0201, 17'h0_027F};
    for (int i = 0; i < 3; i++)
      issue(2'h1, pa[i], 32'hA5A5_0000 + DATA_W'(i));
    for (int i = 0; i < 3; i++)
      rd(pa[i], 32'hA5A5_0000 + DATA_W'(i));
    rd(17'h0_0280, 32'hFFFF_FFFF);
  endtask

  task automatic t_lock;
    issue(2'h2, 17'h0_0300, 32'h0000_00D1);
    rd(17'h0_0300, 32'h0000_00D1);
    issue(2'h1, 17'h0_0300, 32'h0000_00D2);
    rd(17'h0_0300, 32'h0000_00D1);
    issue(2'h3, 17'h0_0301, 32'h0000_00E1);
    issue(2'h1, 17'h0_0302, 32'h0000_00D3);
    rd(17'h0_0302, 32'h0000_00D3);
    rd(17'h0_0301, 32'hFFFF_FFFF);
  endtask

  task automatic t_protect;
    @(posedge clk);
    protect_req <= 1'b1;
    repeat (60) @(negedge clk);
    check({31'h0, protect_active}, 32'h1);
    check({31'h0, program_protect_n}, 32'h0);
    check({31'h0, cmd_ready}, 32'h0);
    @(posedge clk);
    protect_req <= 1'b0;
    rd(17'h0_0100, 32'h1234_5678);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    check({31'h0, protect_active}, 32'h1);
    check({31'h0, cmd_ready}, 32'h0);
    nrst <= 1'b1;
    t_settle;
    t_write_read;
    t_page;
    t_lock;
    t_protect;
    complete_run;
  end

  // The sequence needs some 2k cycles; the limit of 60k cycles leaves ample margin.
  initial begin
    #1200000;
    mismatches++;
    complete_run;
  end
endmodule
